/* File: core/drive_status_output_compare.sv */
// Summary of operation
// - Code 01: constant-speed flag on at set speed, off when stopped or ramping.
// - Code 02: over-frequency flag on at or above thresholds, off when stopped.
// - Every frequency threshold turns the flag on 1.5 Hz early.
// - Moving away, the flag turns off only 0.5 Hz past the threshold.
// - Frequency flags reach the pin 60 ms after their condition changes.
// - Constant-speed band: on within 1% of max, off beyond 2% of max.
// - Over-frequency uses accel-on threshold accelerating, decel-off decelerating.
// - Equal accel and decel thresholds are allowed: on 1.5 Hz below, off 0.5 Hz below the shared value while decelerating, 1.5 Hz below at steady speed.
// - Every terminal is active low: the transistor conducts when flag set.
// - Both terminals may carry frequency flags, each evaluated independently.
// - Code 03: overload flag on above the level, off below it.
// - Overload compares current magnitude in motoring and regeneration alike.
// - Overload level resets to 100% of rated current.
// - Code 04: deviation flag on when abs(setpoint-PV) exceeds the level.
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/10ps
`include "dso_defines.svh"

module drive_status_output_compare
	import dso_pkg::*;
#(
	parameter int DLY_CYC = `DSO_FA_DLY_CYC
) (
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic [5:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	input wire logic i_out_on,
	input wire logic i_ramp_up,
	input wire logic i_ramp_down,
	input wire logic [15:0] i_out_freq,
	input wire logic signed [15:0] i_out_current,
	input wire logic signed [15:0] i_setpoint,
	input wire logic signed [15:0] i_proc_var,
	output logic [1:0] o_term_n,
	output logic o_irq
);

	localparam logic [`DSO_CNT_W-1:0] DLY_LAST =
		`DSO_CNT_W'(DLY_CYC - 1);

	state_t q;
	state_t d;
	logic [16:0] freq;
	logic [16:0] fon;
	logic [16:0] foff;
	logic [16:0] dist1;
	logic [15:0] cur_mag;
	logic [16:0] err_mag;
	logic const_in_on;
	logic const_out_off;
	logic over_set;
	logic over_clr;
	logic [3:0] clr_mask;

	// Magnitude of a signed difference, one bit wider
	function automatic logic [16:0] abs_diff(
		input logic signed [15:0] a,
		input logic signed [15:0] b);
		logic signed [16:0] t;
		t = 17'(a) - 17'(b);
		abs_diff = t[16] ? 17'(-t) : 17'(t);
	endfunction

	// Option code to flag selection, unknown codes keep the pin off
	function automatic logic pick(input logic [7:0] sel,
		input logic [3:0] f);
		case (sel)
			`DSO_OPT_CONST: pick = f[`DSO_BIT_CONST];
			`DSO_OPT_OVER: pick = f[`DSO_BIT_OVER];
			`DSO_OPT_OVLD: pick = f[`DSO_BIT_OVLD];
			`DSO_OPT_DEV: pick = f[`DSO_BIT_DEV];
			default: pick = 1'b0;
		endcase
	endfunction

	// Comparison terms from the measurements
	always_comb begin
		freq = {1'b0, i_out_freq};
		fon = 17'((32'(q.max_frq) * `DSO_FON_PCT) / 100);
		foff = 17'((32'(q.max_frq) * `DSO_FOFF_PCT) / 100);
		dist1 = freq > {1'b0, q.set_spd} ?
			freq - {1'b0, q.set_spd} : {1'b0, q.set_spd} - freq;
		// Band widened early on entry and late on exit
		const_in_on = dist1 <= fon + `DSO_ANTIC_HZ10;
		const_out_off = dist1 > foff + `DSO_LAG_HZ10;
		// Over-frequency switches on accel, off on decel thresholds
		over_set = !i_ramp_down &&
			freq + `DSO_ANTIC_HZ10 >= {1'b0, q.acc_thr};
		over_clr = !i_ramp_up &&
			freq + `DSO_LAG_HZ10 < {1'b0, q.dec_thr};
		// Current magnitude covers motoring and regeneration
		cur_mag = i_out_current[15] ? 16'(-i_out_current) :
			16'(i_out_current);
		err_mag = abs_diff(i_setpoint, i_proc_var);
		clr_mask = (i_wr && i_addr == `DSO_ADDR_IRQ_CLR) ?
			i_wdata[3:0] : 4'h0;
	end

	// Next state
	always_comb begin
		d = q;
		// Raw constant-speed flag
		if (!i_out_on || i_ramp_up || i_ramp_down) begin
			d.raw[`DSO_BIT_CONST] = 1'b0;
		end else if (const_in_on) begin
			d.raw[`DSO_BIT_CONST] = 1'b1;
		end else if (const_out_off) begin
			d.raw[`DSO_BIT_CONST] = 1'b0;
		end
		// Raw over-frequency flag, active through ramps
		if (!i_out_on) begin
			d.raw[`DSO_BIT_OVER] = 1'b0;
		end else if (!q.raw[`DSO_BIT_OVER] && over_set) begin
			d.raw[`DSO_BIT_OVER] = 1'b1;
		end else if (q.raw[`DSO_BIT_OVER] && over_clr && !over_set) begin
			// Set term wins at steady speed so the flag cannot chatter
			d.raw[`DSO_BIT_OVER] = 1'b0;
		end
		// Overload: above sets, below clears, equal holds
		if (cur_mag > q.ovl_lvl) begin
			d.raw[`DSO_BIT_OVLD] = 1'b1;
		end else if (cur_mag < q.ovl_lvl) begin
			d.raw[`DSO_BIT_OVLD] = 1'b0;
		end
		// Loop deviation: same scheme on the error magnitude
		if (err_mag > {1'b0, q.dev_lvl}) begin
			d.raw[`DSO_BIT_DEV] = 1'b1;
		end else if (err_mag < {1'b0, q.dev_lvl}) begin
			d.raw[`DSO_BIT_DEV] = 1'b0;
		end
		// Frequency flags follow their raw value once it held 60 ms
		if (q.raw[`DSO_BIT_CONST] == q.flag[`DSO_BIT_CONST]) begin
			d.cnt1 = '0;
		end else if (q.cnt1 == DLY_LAST) begin
			d.cnt1 = '0;
			d.flag[`DSO_BIT_CONST] = q.raw[`DSO_BIT_CONST];
		end else begin
			d.cnt1 = q.cnt1 + 1'b1;
		end
		if (q.raw[`DSO_BIT_OVER] == q.flag[`DSO_BIT_OVER]) begin
			d.cnt2 = '0;
		end else if (q.cnt2 == DLY_LAST) begin
			d.cnt2 = '0;
			d.flag[`DSO_BIT_OVER] = q.raw[`DSO_BIT_OVER];
		end else begin
			d.cnt2 = q.cnt2 + 1'b1;
		end
		d.flag[`DSO_BIT_OVLD] = q.raw[`DSO_BIT_OVLD];
		d.flag[`DSO_BIT_DEV] = q.raw[`DSO_BIT_DEV];
		// Rising flags raise sticky status; a new set beats a clear
		d.prev = q.flag;
		d.ist = (q.ist & ~clr_mask) | (q.flag & ~q.prev);
		d.irq = |(d.ist & q.ien);
		// Each terminal picks its own flag, conducting when set
		d.term_n[0] = !pick(q.sel0, q.flag);
		d.term_n[1] = !pick(q.sel1, q.flag);
		// Register writes
		if (i_wr) begin
			case (i_addr)
				`DSO_ADDR_SEL: begin
					d.sel0 = i_wdata[7:0];
					d.sel1 = i_wdata[15:8];
				end
				`DSO_ADDR_SET_SPD: d.set_spd = i_wdata;
				`DSO_ADDR_MAX_FRQ: d.max_frq = i_wdata;
				`DSO_ADDR_OVL_LVL: d.ovl_lvl = i_wdata;
				`DSO_ADDR_ACC_THR: d.acc_thr = i_wdata;
				`DSO_ADDR_DEC_THR: d.dec_thr = i_wdata;
				`DSO_ADDR_DEV_LVL: d.dev_lvl = i_wdata;
				`DSO_ADDR_IRQ_EN: d.ien = i_wdata[3:0];
				default: ;
			endcase
		end
		// Register reads, data valid in the following cycle only
		d.rdata = 16'h0000;
		if (i_rd) begin
			case (i_addr)
				`DSO_ADDR_SEL: d.rdata = {q.sel1, q.sel0};
				`DSO_ADDR_SET_SPD: d.rdata = q.set_spd;
				`DSO_ADDR_MAX_FRQ: d.rdata = q.max_frq;
				`DSO_ADDR_OVL_LVL: d.rdata = q.ovl_lvl;
				`DSO_ADDR_ACC_THR: d.rdata = q.acc_thr;
				`DSO_ADDR_DEC_THR: d.rdata = q.dec_thr;
				`DSO_ADDR_DEV_LVL: d.rdata = q.dev_lvl;
				`DSO_ADDR_FLAGS: d.rdata = {8'h00, q.raw, q.flag};
				`DSO_ADDR_IRQ_ST: d.rdata = {12'h000, q.ist};
				`DSO_ADDR_IRQ_EN: d.rdata = {12'h000, q.ien};
				default: d.rdata = 16'h0000;
			endcase
		end
	end

	// State register, flags cleared and pins released in reset
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			q <= '0;
			q.term_n <= 2'h3;
			q.sel0 <= `DSO_RST_SEL0;
			q.sel1 <= `DSO_RST_SEL1;
			q.set_spd <= `DSO_RST_SET_SPD;
			q.max_frq <= `DSO_RST_MAX_FRQ;
			q.ovl_lvl <= `DSO_RST_OVL_LVL;
			q.acc_thr <= `DSO_RST_ACC_THR;
			q.dec_thr <= `DSO_RST_DEC_THR;
			q.dev_lvl <= `DSO_RST_DEV_LVL;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from flip-flops
	assign o_rdata = q.rdata;
	assign o_term_n = q.term_n;
	assign o_irq = q.irq;

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rstn);

	// Constant-speed flag never stands while stopped or ramping
	property p_const_steady;
		(!i_out_on || i_ramp_up || i_ramp_down) |=>
			!q.raw[`DSO_BIT_CONST];
	endproperty
	a_const_steady: assert property (p_const_steady)
		else $error("constant-speed flag set while not steady");

	// Over-frequency drops with the output off
	property p_over_off;
		!i_out_on |=> !q.raw[`DSO_BIT_OVER];
	endproperty
	a_over_off: assert property (p_over_off)
		else $error("over-frequency flag set with output off");

	// Over-frequency turns on 1.5 Hz before the accel threshold
	property p_over_early;
		(i_out_on && !i_ramp_down &&
			17'(i_out_freq) + 17'd15 >= 17'(q.acc_thr)) |=>
			q.raw[`DSO_BIT_OVER];
	endproperty
	a_over_early: assert property (p_over_early)
		else $error("over-frequency flag not set early");

	// Over-frequency holds until 0.5 Hz below the decel threshold
	property p_over_hold;
		(i_out_on && q.raw[`DSO_BIT_OVER] && !i_ramp_up &&
			17'(i_out_freq) + 17'd5 >= 17'(q.dec_thr)) |=>
			q.raw[`DSO_BIT_OVER];
	endproperty
	a_over_hold: assert property (p_over_hold)
		else $error("over-frequency flag dropped inside lag");

	// Presented flag only moves when the delay counter expires
	property p_const_delay;
		$changed(q.flag[`DSO_BIT_CONST]) |->
			$past(q.raw[`DSO_BIT_CONST] != q.flag[`DSO_BIT_CONST]) &&
			$past(q.cnt1) == DLY_LAST;
	endproperty
	a_const_delay: assert property (p_const_delay)
		else $error("constant-speed flag moved before delay");

	// An expired delay counter hands the raw value on
	sequence s_const_wait;
		q.raw[`DSO_BIT_CONST] != q.flag[`DSO_BIT_CONST] &&
			q.cnt1 == DLY_LAST;
	endsequence
	property p_const_move;
		s_const_wait |=> $changed(q.flag[`DSO_BIT_CONST]);
	endproperty
	a_const_move: assert property (p_const_move)
		else $error("constant-speed flag missed its delay expiry");

	// Leaving the off band drops the constant-speed flag
	property p_const_band;
		(dist1 > fon + 17'd15 && dist1 > foff + 17'd5) |=>
			!q.raw[`DSO_BIT_CONST];
	endproperty
	a_const_band: assert property (p_const_band)
		else $error("constant-speed flag outside off band");

	// Terminal zero conducts exactly when its flag was set
	property p_term0;
		##1 o_term_n[0] == !pick($past(q.sel0), $past(q.flag));
	endproperty
	a_term0: assert property (p_term0)
		else $error("terminal zero polarity wrong");

	// Overload sets on the current magnitude in both directions
	property p_ovl;
		(cur_mag > q.ovl_lvl) |=> q.raw[`DSO_BIT_OVLD] ##1
			q.flag[`DSO_BIT_OVLD];
	endproperty
	a_ovl: assert property (p_ovl)
		else $error("overload flag missed");

	// Deviation flag cleared when the error is below the level
	property p_dev;
		(err_mag < 17'(q.dev_lvl)) |=> !q.raw[`DSO_BIT_DEV];
	endproperty
	a_dev: assert property (p_dev)
		else $error("deviation flag not cleared");

	// Overload level starts at full rated current
	property p_ovl_rst;
		$rose(i_rstn) |-> q.ovl_lvl == 16'h03E8;
	endproperty
	a_ovl_rst: assert property (p_ovl_rst)
		else $error("overload level reset value wrong");

	// Pins released and interrupt low as reset lifts
	property p_rst_pins;
		$rose(i_rstn) |-> o_term_n == 2'h3 && !o_irq;
	endproperty
	a_rst_pins: assert property (p_rst_pins)
		else $error("terminal or interrupt active out of reset");

endmodule

/* File: core/dso_defines.svh */
`ifndef DSO_DEFINES_SVH
`define DSO_DEFINES_SVH

// Register byte offsets
`define DSO_ADDR_SEL 6'h00
`define DSO_ADDR_SET_SPD 6'h04
`define DSO_ADDR_MAX_FRQ 6'h08
`define DSO_ADDR_OVL_LVL 6'h0C
`define DSO_ADDR_ACC_THR 6'h10
`define DSO_ADDR_DEC_THR 6'h14
`define DSO_ADDR_DEV_LVL 6'h18
`define DSO_ADDR_FLAGS 6'h1C
`define DSO_ADDR_IRQ_ST 6'h20
`define DSO_ADDR_IRQ_CLR 6'h24
`define DSO_ADDR_IRQ_EN 6'h28

// Flag bit positions
`define DSO_BIT_CONST 0
`define DSO_BIT_OVER 1
`define DSO_BIT_OVLD 2
`define DSO_BIT_DEV 3

// Option codes
`define DSO_OPT_CONST 8'h01
`define DSO_OPT_OVER 8'h02
`define DSO_OPT_OVLD 8'h03
`define DSO_OPT_DEV 8'h04

// Reset values (frequency 0.1 Hz, current and error 0.1 %)
`define DSO_RST_SEL0 8'h01
`define DSO_RST_SEL1 8'h03
`define DSO_RST_SET_SPD 16'h01F4
`define DSO_RST_MAX_FRQ 16'h0258
`define DSO_RST_OVL_LVL 16'h03E8
`define DSO_RST_ACC_THR 16'h0000
`define DSO_RST_DEC_THR 16'h0000
`define DSO_RST_DEV_LVL 16'h001E

// Hysteresis figures in 0.1 Hz units: 1.5 Hz early, 0.5 Hz late
`define DSO_ANTIC_HZ10 17'h0000F
`define DSO_LAG_HZ10 17'h00005
// Band figures in percent of maximum frequency
`define DSO_FON_PCT 1
`define DSO_FOFF_PCT 2

// Output delay: 60 ms at 100 MHz
`define DSO_CLK_MHZ 100
`define DSO_FA_DLY_MS 60
`define DSO_FA_DLY_CYC (`DSO_FA_DLY_MS * 1000 * `DSO_CLK_MHZ)
`define DSO_CNT_W 23

`endif

/* File: core/dso_pkg.sv */
`include "dso_defines.svh"

package dso_pkg;
	typedef struct packed {
		logic [7:0] sel0;
		logic [7:0] sel1;
		logic [15:0] set_spd;
		logic [15:0] max_frq;
		logic [15:0] ovl_lvl;
		logic [15:0] acc_thr;
		logic [15:0] dec_thr;
		logic [15:0] dev_lvl;
		logic [3:0] raw;
		logic [3:0] flag;
		logic [3:0] prev;
		logic [`DSO_CNT_W-1:0] cnt1;
		logic [`DSO_CNT_W-1:0] cnt2;
		logic [3:0] ist;
		logic [3:0] ien;
		logic [15:0] rdata;
		logic irq;
		logic [1:0] term_n;
	} state_t;
endpackage

/* File: sim/oc_load_model.sv */
`timescale 1ns/10ps

// Relay coil loads on the two terminals, each pulled up to the supply
module oc_load_model (
	input wire logic [1:0] i_term_n,
	output logic [1:0] o_energized
);
	// Coil current flows only while the transistor pulls the pin low
	assign o_energized = ~i_term_n;
endmodule

/* File: sim/testbench.sv */
`timescale 1ns/10ps
`include "dso_defines.svh"

module testbench
	import dso_pkg::*;
;
	logic i_clk_sys, i_rstn, i_wr, i_rd, i_out_on, i_ramp_up, i_ramp_down;
	logic [5:0] i_addr;
	logic [15:0] i_wdata, i_out_freq, o_rdata;
	logic signed [15:0] i_out_current, i_setpoint, i_proc_var;
	logic [1:0] o_term_n, energized;
	logic o_irq;
	int failures = 0;
	int comparisons = 0;

	// Short output delay keeps the run brief
	drive_status_output_compare #(.DLY_CYC(8)) u_dut (
		.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_out_on(i_out_on), .i_ramp_up(i_ramp_up),
		.i_ramp_down(i_ramp_down), .i_out_freq(i_out_freq),
		.i_out_current(i_out_current), .i_setpoint(i_setpoint),
		.i_proc_var(i_proc_var), .o_term_n(o_term_n), .o_irq(o_irq)
	);

	oc_load_model u_load (
		.i_term_n(o_term_n),
		.o_energized(energized)
	);

	// 100 MHz system clock
	initial begin
		i_clk_sys = 1'b0;
		forever #5 i_clk_sys = ~i_clk_sys;
	end

	task automatic print_verdict();
		if (failures == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// One-cycle write strobe
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge i_clk_sys);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
	endtask

	// One-cycle read strobe, data taken in the following cycle
	task automatic rd_reg(input logic [5:0] a, input logic [15:0] exp);
		@(posedge i_clk_sys);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, exp);
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask

	// Bounded wait for a load to reach the given state
	task automatic wait_on(input int b, input logic v);
		int n;
		n = 0;
		while (energized[b] !== v && n < 40) begin
			@(posedge i_clk_sys);
			#1;
			n++;
		end
		chk({15'h0000, energized[b]}, {15'h0000, v});
		if (n >= 40) begin
			print_verdict();
		end
	endtask

	// Main sequence
	initial begin
		i_rstn = 1'b0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = 6'h00;
		i_wdata = 16'h0000;
		i_out_on = 1'b0;
		i_ramp_up = 1'b0;
		i_ramp_down = 1'b0;
		i_out_freq = 16'h0000;
		i_out_current = 16'sh0000;
		i_setpoint = 16'sh0000;
		i_proc_var = 16'sh0000;
		settle(3);
		chk({14'h0000, energized}, 16'h0000);
		chk({15'h0000, o_irq}, 16'h0000);
		repeat (3) @(posedge i_clk_sys);
		i_rstn <= 1'b1;
		rd_reg(`DSO_ADDR_OVL_LVL, 16'h03E8);
		rd_reg(6'h3C, 16'h0000);
		rd_reg(`DSO_ADDR_SEL, 16'h0301);
		// Overload on terminal 1 with its interrupt enabled
		wr(`DSO_ADDR_IRQ_EN, 16'h0004);
		@(posedge i_clk_sys);
		i_out_current <= 16'sd1001;
		wait_on(1, 1'b1);
		chk({15'h0000, o_irq}, 16'h0001);
		rd_reg(`DSO_ADDR_IRQ_ST, 16'h0004);
		wr(`DSO_ADDR_IRQ_CLR, 16'h0004);
		settle(3);
		chk({15'h0000, o_irq}, 16'h0000);
		i_out_current <= 16'sd999;
		wait_on(1, 1'b0);
		i_out_current <= -16'sd1001;
		wait_on(1, 1'b1);
		i_out_current <= 16'sh0000;
		wait_on(1, 1'b0);
		// Constant speed on terminal 0: set 50.0 Hz, max 60.0 Hz
		@(posedge i_clk_sys);
		i_out_on <= 1'b1;
		i_out_freq <= 16'd480;
		settle(9);
		chk({15'h0000, energized[0]}, 16'h0000);
		settle(1);
		chk({15'h0000, energized[0]}, 16'h0001);
		wait_on(0, 1'b1);
		i_ramp_up <= 1'b1;
		wait_on(0, 1'b0);
		i_ramp_up <= 1'b0;
		i_out_freq <= 16'd523;
		settle(15);
		chk({15'h0000, energized[0]}, 16'h0000);
		// Both terminals on frequency flags, equal thresholds at 30.0 Hz
		wr(`DSO_ADDR_SEL, 16'h0201);
		wr(`DSO_ADDR_ACC_THR, 16'd300);
		wr(`DSO_ADDR_DEC_THR, 16'd300);
		@(posedge i_clk_sys);
		i_out_freq <= 16'd500;
		wait_on(1, 1'b1);
		wait_on(0, 1'b1);
		i_out_on <= 1'b0;
		wait_on(1, 1'b0);
		i_out_on <= 1'b1;
		i_ramp_up <= 1'b1;
		i_out_freq <= 16'd284;
		settle(15);
		chk({15'h0000, energized[1]}, 16'h0000);
		i_out_freq <= 16'd285;
		wait_on(1, 1'b1);
		i_ramp_up <= 1'b0;
		i_ramp_down <= 1'b1;
		i_out_freq <= 16'd295;
		settle(15);
		chk({15'h0000, energized[1]}, 16'h0001);
		i_out_freq <= 16'd294;
		wait_on(1, 1'b0);
		// Deviation on terminal 0, terminal 1 given an unused code
		wr(`DSO_ADDR_SEL, 16'h0004);
		@(posedge i_clk_sys);
		i_setpoint <= 16'sd100;
		i_proc_var <= 16'sd131;
		wait_on(0, 1'b1);
		chk({15'h0000, energized[1]}, 16'h0000);
		i_proc_var <= 16'sd129;
		wait_on(0, 1'b0);
		i_proc_var <= 16'sd69;
		wait_on(0, 1'b1);
		rd_reg(`DSO_ADDR_FLAGS, 16'h0088);
		wr(`DSO_ADDR_OVL_LVL, 16'd1200);
		rd_reg(`DSO_ADDR_OVL_LVL, 16'd1200);
		chk({15'h0000, o_irq}, 16'h0001);
		// Reset in mid-run releases the pins and restores the levels
		i_rstn <= 1'b0;
		settle(2);
		chk({14'h0000, energized}, 16'h0000);
		chk({15'h0000, o_irq}, 16'h0000);
		i_rstn <= 1'b1;
		rd_reg(`DSO_ADDR_OVL_LVL, 16'h03E8);
		rd_reg(`DSO_ADDR_SEL, 16'h0301);
		// Raised deviation level drops the flag again
		wr(`DSO_ADDR_SEL, 16'h0004);
		wait_on(0, 1'b1);
		wr(`DSO_ADDR_DEV_LVL, 16'd40);
		rd_reg(`DSO_ADDR_DEV_LVL, 16'd40);
		wait_on(0, 1'b0);
		print_verdict();
	end
endmodule
